// ===== src/cis_consts.svh
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define CIS_OFF_CORE 8'h00
`define CIS_OFF_PFLAG1 8'h04
`define CIS_OFF_PFLAG2 8'h08
`define CIS_OFF_PEN1 8'h0C
`define CIS_OFF_PEN2 8'h10
`define CIS_OFF_STAT 8'h14
`define CIS_OFF_IEN 8'h18
`define CIS_OFF_ICLR 8'h1C
`define CIS_OFF_TIMING 8'h20
// ------------------------------------------------------------
// Core control register bit positions
// ------------------------------------------------------------
`define CIS_B_GIE 7
`define CIS_B_PERIPHERAL_GROUP_IRQ_ENABLE 6
`define CIS_CORE_EN_HI 5
`define CIS_CORE_EN_LO 3
`define CIS_CORE_FL_HI 2
`define CIS_CORE_FL_LO 0
// Status register: bit 0 entry taken, bit 1 return done
`define CIS_ST_ENTRY 0
`define CIS_ST_RET 1
// ------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------
`define CIS_RST_BYTE 8'h00
`define CIS_VECTOR 15'h0004
`define CIS_DEPTH 16
`define CIS_SP_ONE 5'h01
// Instruction cycle of 4 system clocks (Q1..Q4)
`define CIS_QCLKS 2'h3
// Entry spends two flush cycles after the sampling cycle
`define CIS_FLUSH_CYC 2'h1
`endif

// ===== src/cis_core_interrupt_sequencer.sv
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "cis_consts.svh"
module cis_core_interrupt_sequencer
  import cis_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt sources, one-cycle pulses
  input wire logic [2:0] core_event_i,
  input wire logic [7:0] periph_event_one_i,
  input wire logic [7:0] periph_event_two_i,
  // CPU core
  input wire logic [14:0] pc_i,
  input wire logic return_from_irq_instruction_i,
  input wire logic [14:0] stack_top_i,
  input wire logic wake_from_sleep_i,
  input wire logic [7:0] w_i,
  input wire logic [7:0] status_i,
  input wire logic [4:0] bank_select_register_i,
  input wire logic [15:0] file_select_register0_i,
  input wire logic [15:0] file_select_register1_i,
  input wire logic [6:0] program_counter_high_latch_i,
  output logic flush_o,
  output logic push_o,
  output logic pop_o,
  output logic [14:0] push_pc_o,
  output logic pc_load_o,
  output logic [14:0] pc_load_value_o,
  output logic restore_o,
  output logic [7:0] w_shadow_o,
  output logic [7:0] status_shadow_o,
  output logic [4:0] bsr_shadow_o,
  output logic [15:0] fsr0_shadow_o,
  output logic [15:0] fsr1_shadow_o,
  output logic [6:0] program_counter_high_latch_shadow_o,
  output logic irq_request_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] core_irq_control_reg_r;
  logic [7:0] peripheral_flag_reg_one_r;
  logic [7:0] peripheral_flag_reg_two_r;
  logic [7:0] peripheral_enable_reg_one_r;
  logic [7:0] peripheral_enable_reg_two_r;
  logic [1:0] sts_r;
  logic [1:0] ien_r;
  logic ack_r;
  logic [1:0] qcnt_r;
  logic [1:0] fcnt_r;
  logic wake_hold_r;
  cis_state_e state_r;

  logic global_irq_enable;
  logic peripheral_group_irq_enable;
  logic wr_ok;
  logic req_raw;
  logic take;
  logic q_end;
  logic entry_pulse;
  logic ret_pulse;
  logic [2:0] core_wr_clr;

  assign global_irq_enable = core_irq_control_reg_r[`CIS_B_GIE];
  assign peripheral_group_irq_enable = core_irq_control_reg_r[`CIS_B_PERIPHERAL_GROUP_IRQ_ENABLE];
  assign wr_ok = cyc_i && stb_i && we_i && !ack_r && sel_i[0];
  assign q_end = (qcnt_r == `CIS_QCLKS);

  // ------------------------------------------------------------
  // Request forming
  // ------------------------------------------------------------
  logic [2:0] core_pairs;
  assign core_pairs = core_irq_control_reg_r[`CIS_CORE_EN_HI:`CIS_CORE_EN_LO]
                    & core_irq_control_reg_r[`CIS_CORE_FL_HI:`CIS_CORE_FL_LO];
  assign req_raw = (|core_pairs)
    || (peripheral_group_irq_enable &&
        (|(peripheral_flag_reg_one_r & peripheral_enable_reg_one_r)
         || |(peripheral_flag_reg_two_r & peripheral_enable_reg_two_r)));
  // Pending flags are level: a request left standing is taken when GLOBAL_IRQ_ENABLE returns
  assign irq_request_o = req_raw && global_irq_enable;
  // Sampled at the end of an instruction cycle; wake holds off one cycle
  assign take = (state_r == CIS_RUN) && q_end && irq_request_o && !wake_hold_r;
  assign entry_pulse = (state_r == CIS_VECT) && q_end;
  assign ret_pulse = return_from_irq_instruction_i && (state_r == CIS_RUN);

  // ------------------------------------------------------------
  // Instruction cycle divider
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qcnt_r <= 2'h0;
    end else begin
      qcnt_r <= qcnt_r + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Entry sequence: sample, two flush cycles, vector
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= CIS_RUN;
      fcnt_r <= 2'h0;
    end else begin
      case (state_r)
        CIS_RUN: begin
          if (take) begin
            state_r <= CIS_FLUSH;
            fcnt_r <= 2'h0;
          end
        end
        CIS_FLUSH: begin
          if (q_end) begin
            if (fcnt_r == `CIS_FLUSH_CYC) begin
              state_r <= CIS_VECT;
            end else begin
              fcnt_r <= fcnt_r + 2'h1;
            end
          end
        end
        CIS_VECT: begin
          if (q_end) begin
            state_r <= CIS_RUN;
          end
        end
        default: begin
          state_r <= CIS_RUN;
        end
      endcase
    end
  end

  // Instruction after sleep runs before vectoring unless a take lands in the wake cycle itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_hold_r <= 1'b0;
    end else if (wake_from_sleep_i) begin
      wake_hold_r <= 1'b1;
    end else if (q_end) begin
      wake_hold_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // CPU control outputs and shadow context
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_o <= 1'b0;
      push_o <= 1'b0;
      pop_o <= 1'b0;
      push_pc_o <= 15'h0000;
      pc_load_o <= 1'b0;
      pc_load_value_o <= 15'h0000;
      restore_o <= 1'b0;
    end else begin
      flush_o <= take;
      push_o <= take;
      push_pc_o <= take ? pc_i : push_pc_o;
      pop_o <= ret_pulse;
      restore_o <= ret_pulse;
      pc_load_o <= entry_pulse || ret_pulse;
      if (entry_pulse) begin
        pc_load_value_o <= `CIS_VECTOR;
      end else if (ret_pulse) begin
        pc_load_value_o <= stack_top_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_shadow_o <= 8'h00;
      status_shadow_o <= 8'h00;
      bsr_shadow_o <= 5'h00;
      fsr0_shadow_o <= 16'h0000;
      fsr1_shadow_o <= 16'h0000;
      program_counter_high_latch_shadow_o <= 7'h00;
    end else if (take) begin
      w_shadow_o <= w_i;
      // Timeout and power-down bits (4,3) are left out of the copy
      status_shadow_o <= {status_i[7:5], 2'b00, status_i[2:0]};
      bsr_shadow_o <= bank_select_register_i;
      fsr0_shadow_o <= file_select_register0_i;
      fsr1_shadow_o <= file_select_register1_i;
      program_counter_high_latch_shadow_o <= program_counter_high_latch_i;
    end
  end

  // ------------------------------------------------------------
  // Flag and enable registers
  // ------------------------------------------------------------
  assign core_wr_clr = ~dat_i[`CIS_CORE_FL_HI:`CIS_CORE_FL_LO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_irq_control_reg_r <= `CIS_RST_BYTE;
    end else begin
      if (wr_ok && adr_i == `CIS_OFF_CORE) begin
        core_irq_control_reg_r[7:3] <= dat_i[7:3];
        core_irq_control_reg_r[2:0] <= (core_irq_control_reg_r[2:0] & ~core_wr_clr)
                                     | (dat_i[2:0] & ~core_irq_control_reg_r[2:0])
                                     | core_event_i;
      end else begin
        core_irq_control_reg_r[2:0] <= core_irq_control_reg_r[2:0] | core_event_i;
      end
      if (take) begin
        core_irq_control_reg_r[`CIS_B_GIE] <= 1'b0;
      end else if (ret_pulse) begin
        core_irq_control_reg_r[`CIS_B_GIE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_flag_reg_one_r <= `CIS_RST_BYTE;
      peripheral_flag_reg_two_r <= `CIS_RST_BYTE;
    end else begin
      // Hardware set wins over a same-cycle software clear
      if (wr_ok && adr_i == `CIS_OFF_PFLAG1) begin
        peripheral_flag_reg_one_r <= dat_i[7:0] | periph_event_one_i;
      end else begin
        peripheral_flag_reg_one_r <= peripheral_flag_reg_one_r | periph_event_one_i;
      end
      if (wr_ok && adr_i == `CIS_OFF_PFLAG2) begin
        peripheral_flag_reg_two_r <= dat_i[7:0] | periph_event_two_i;
      end else begin
        peripheral_flag_reg_two_r <= peripheral_flag_reg_two_r | periph_event_two_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_enable_reg_one_r <= `CIS_RST_BYTE;
      peripheral_enable_reg_two_r <= `CIS_RST_BYTE;
      ien_r <= 2'h0;
    end else if (wr_ok) begin
      if (adr_i == `CIS_OFF_PEN1) begin
        peripheral_enable_reg_one_r <= dat_i[7:0];
      end else if (adr_i == `CIS_OFF_PEN2) begin
        peripheral_enable_reg_two_r <= dat_i[7:0];
      end else if (adr_i == `CIS_OFF_IEN) begin
        ien_r <= dat_i[1:0];
      end
    end
  end

  // Sequencer event status, write-one-to-clear via clear register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_r <= 2'h0;
    end else begin
      sts_r <= (sts_r & ~((wr_ok && adr_i == `CIS_OFF_ICLR) ? dat_i[1:0] : 2'h0))
             | {ret_pulse, entry_pulse};
    end
  end
  assign irq_o = |(sts_r & ien_r);

  // ------------------------------------------------------------
  // Wishbone read and acknowledge
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
      if (adr_i == `CIS_OFF_CORE) begin
        dat_o <= {24'h000000, core_irq_control_reg_r};
      end else if (adr_i == `CIS_OFF_PFLAG1) begin
        dat_o <= {24'h000000, peripheral_flag_reg_one_r};
      end else if (adr_i == `CIS_OFF_PFLAG2) begin
        dat_o <= {24'h000000, peripheral_flag_reg_two_r};
      end else if (adr_i == `CIS_OFF_PEN1) begin
        dat_o <= {24'h000000, peripheral_enable_reg_one_r};
      end else if (adr_i == `CIS_OFF_PEN2) begin
        dat_o <= {24'h000000, peripheral_enable_reg_two_r};
      end else if (adr_i == `CIS_OFF_STAT) begin
        dat_o <= {30'h0, sts_r};
      end else if (adr_i == `CIS_OFF_IEN) begin
        dat_o <= {30'h0, ien_r};
      end else if (adr_i == `CIS_OFF_TIMING) begin
        dat_o <= {28'h0000000, wake_hold_r, 1'b0, state_r};
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end
  assign ack_o = ack_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    take;
  endsequence
  sequence s_vector;
    pc_load_o && pc_load_value_o == `CIS_VECTOR;
  endsequence

  chk_reset_disable: assert property ($fell(rst_i) |-> !global_irq_enable)
    else $error("global enable set after reset");
  chk_take_needs_gie: assert property (take |-> global_irq_enable && req_raw)
    else $error("entry without enables");
  chk_group_gate: assert property (take && !peripheral_group_irq_enable |-> |core_pairs)
    else $error("peripheral entry without group enable");
  chk_flag_sets: assert property ((|periph_event_one_i) |=>
    &(peripheral_flag_reg_one_r | ~$past(periph_event_one_i))) else $error("flag not set");
  chk_entry_steps: assert property (s_take |=> flush_o && push_o && !global_irq_enable)
    else $error("entry steps missing");
  chk_vector_time: assert property (s_take |-> ##13 s_vector)
    else $error("vector load late or early");
  chk_no_nested: assert property (!global_irq_enable |=> !push_o)
    else $error("nested entry");
  chk_return_gie: assert property (ret_pulse |=> global_irq_enable && pop_o && restore_o)
    else $error("return did not restore");
  chk_wake_hold: assert property (wake_from_sleep_i |=> !take)
    else $error("vectored before post-sleep instruction");
endmodule

// ===== src/cis_pkg.sv
package cis_pkg;
  typedef enum logic [1:0] {
    CIS_RUN,
    CIS_FLUSH,
    CIS_VECT
  } cis_state_e;
  typedef logic [14:0] cis_pc_t;
endpackage

// ===== testbench/cis_cpu_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// CPU core stand-in: program counter and stack
// ----------------------------------------
module cis_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [14:0] push_pc_i,
  input wire logic pc_load_i,
  input wire logic [14:0] pc_load_value_i,
  output logic [14:0] pc_o,
  output logic [14:0] stack_top_o
);
  logic [14:0] stk_r [16];
  logic [3:0] sp_r;
  // No overflow guard: nesting here stays one level deep
  assign stack_top_o = stk_r[sp_r - 4'h1];
  // PC holds between loads so the pushed value is unambiguous
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= 15'h1A2B;
    end else if (pc_load_i) begin
      pc_o <= pc_load_value_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_r <= 4'h0;
    end else if (push_i) begin
      stk_r[sp_r] <= push_pc_i;
      sp_r <= sp_r + 4'h1;
    end else if (pop_i) begin
      sp_r <= sp_r - 4'h1;
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import cis_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, wake_from_sleep_i;
  logic return_from_irq_instruction_i, flush_o, push_o, pop_o, pc_load_o, restore_o;
  logic irq_request_o, irq_o;
  logic [7:0] adr_i, periph_event_one_i, periph_event_two_i, w_i, status_i;
  logic [7:0] w_shadow_o, status_shadow_o, pb;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd, rnd;
  logic [2:0] core_event_i, kb, jb;
  logic [14:0] pc_i, stack_top_i, push_pc_o, pc_load_value_o, saved_pc;
  logic [4:0] bank_select_register_i, bsr_shadow_o;
  logic [15:0] file_select_register0_i, file_select_register1_i, fsr0_shadow_o, fsr1_shadow_o;
  logic [6:0] program_counter_high_latch_i, program_counter_high_latch_shadow_o;
  int fails, samples_checked, n;

  cis_core_interrupt_sequencer cis_core_interrupt_sequencer_inst (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .core_event_i, .periph_event_one_i,
    .periph_event_two_i, .pc_i, .return_from_irq_instruction_i, .stack_top_i,
    .wake_from_sleep_i, .w_i, .status_i, .bank_select_register_i, .file_select_register0_i,
    .file_select_register1_i, .program_counter_high_latch_i, .flush_o, .push_o, .pop_o,
    .push_pc_o, .pc_load_o, .pc_load_value_o, .restore_o, .w_shadow_o, .status_shadow_o,
    .bsr_shadow_o, .fsr0_shadow_o, .fsr1_shadow_o, .program_counter_high_latch_shadow_o, .irq_request_o, .irq_o);
  cis_cpu_model cis_cpu_model_inst (.clk_i, .rst_i, .push_i(push_o), .pop_i(pop_o),
    .push_pc_i(push_pc_o), .pc_load_i(pc_load_o), .pc_load_value_i(pc_load_value_o),
    .pc_o(pc_i), .stack_top_o(stack_top_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Classic cycle; ends on the ack edge so the next call idles one cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, we, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t bus ack timeout", $time);
    end
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task automatic pulse(input logic [2:0] c, input logic [7:0] p1, input logic [7:0] p2);
    @(posedge clk_i);
    {core_event_i, periph_event_one_i, periph_event_two_i} <= {c, p1, p2};
    @(posedge clk_i);
    {core_event_i, periph_event_one_i, periph_event_two_i} <= 19'h0;
  endtask
  task automatic ctx;
    @(posedge clk_i);
    rnd = xs(rnd);
    {w_i, status_i, bank_select_register_i, program_counter_high_latch_i} <= rnd[27:0];
    rnd = xs(rnd);
    {file_select_register0_i, file_select_register1_i} <= rnd;
  endtask
  // Take may land on the ack edge, so look before waiting
  task automatic entry;
    #1;
    n = 0;
    while (flush_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp(push_o, 1);
    cmp(push_pc_o, pc_i);
    saved_pc = pc_i;
    cmp(w_shadow_o, w_i);
    cmp(status_shadow_o, status_i & 8'hE7);
    cmp(bsr_shadow_o, bank_select_register_i);
    cmp(fsr0_shadow_o, file_select_register0_i);
    cmp(fsr1_shadow_o, file_select_register1_i);
    cmp(program_counter_high_latch_shadow_o, program_counter_high_latch_i);
    n = 0;
    while (pc_load_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp(n, 12);
    cmp(pc_load_value_o, 15'h0004);
  endtask
  task automatic ret;
    @(posedge clk_i);
    return_from_irq_instruction_i <= 1'b1;
    @(posedge clk_i);
    return_from_irq_instruction_i <= 1'b0;
    #1;
    cmp({pop_o, restore_o, pc_load_o}, 3'h7);
    cmp(pc_load_value_o, saved_pc);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, core_event_i, periph_event_one_i} = '0;
    {periph_event_two_i, return_from_irq_instruction_i, wake_from_sleep_i} = '0;
    {w_i, status_i, bank_select_register_i, program_counter_high_latch_i} = '0;
    {file_select_register0_i, file_select_register1_i} = '0;
    rnd = 32'hDC6F8EC8;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    cmp(rd[7:0], 8'h00);
    ctx;
    rnd = xs(rnd);
    kb = 3'h1 << (rnd % 3);
    jb = {kb[1:0], kb[2]};
    pulse(kb, 8'h00, 8'h00);
    wb(1'b0, 8'h00, 32'h0);
    cmp(rd[7:0], {5'h0, kb});
    wb(1'b1, 8'h00, {24'h0, 5'h07, kb});
    cmp(irq_request_o, 0);
    wb(1'b1, 8'h00, {24'h0, 5'h17, kb});
    entry;
    pulse(jb, 8'h00, 8'h00);
    wb(1'b0, 8'h00, 32'h0);
    cmp(rd[7:0], {5'h07, kb | jb});
    cmp(irq_request_o, 0);
    wb(1'b1, 8'h00, 32'h38);
    ret;
    wb(1'b0, 8'h00, 32'h0);
    cmp(rd[7:0], 8'hB8);
    for (int r = 0; r < 2; r++) begin
      ctx;
      rnd = xs(rnd);
      pb = 8'h1 << rnd[2:0];
      pulse(3'h0, r ? 8'h00 : pb, r ? pb : 8'h00);
      wb(1'b1, 8'h0C + 8'(4 * r), {24'h0, pb});
      cmp(irq_request_o, 0);
      wb(1'b0, 8'h04 + 8'(4 * r), 32'h0);
      cmp(rd[7:0], pb);
      wb(1'b1, 8'h00, 32'hF8);
      entry;
      wb(1'b1, 8'h04 + 8'(4 * r), 32'h0);
      wb(1'b1, 8'h00, 32'h38);
      ret;
    end
    // Wake with a core event: the next instruction boundary must pass first
    @(posedge clk_i);
    {wake_from_sleep_i, core_event_i} <= 4'h9;
    @(posedge clk_i);
    {wake_from_sleep_i, core_event_i} <= 4'h0;
    repeat (5) begin
      #1;
      cmp(flush_o, 0);
      @(posedge clk_i);
    end
    entry;
    wb(1'b1, 8'h00, 32'h38);
    ret;
    wb(1'b0, 8'h14, 32'h0);
    cmp(rd[1:0], 2'h3);
    wb(1'b1, 8'h18, 32'h1);
    cmp(irq_o, 1);
    wb(1'b1, 8'h18, 32'h0);
    cmp(irq_o, 0);
    wb(1'b1, 8'h18, 32'h3);
    wb(1'b1, 8'h1C, 32'h3);
    cmp(irq_o, 0);
    wb(1'b0, 8'h14, 32'h0);
    cmp(rd[1:0], 2'h0);
    wb(1'b0, 8'h24, 32'h0);
    cmp(rd, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    cmp(rd[7:0], 8'h00);
    wb(1'b0, 8'h0C, 32'h0);
    cmp(rd[7:0], 8'h00);
    finish_test;
  end
endmodule
